// ==== shared/mpp_pkg.sv ====
// Package for the multiplexed parallel memory port: modes, states, timing, carriers.
// Assumes a single 40 MHz clock domain.
`default_nettype none
package mpp_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned ADDR_PHASE_NS  = 50;
  localparam int unsigned DATA_PHASE_NS  = 75;
  localparam logic [3:0]  ADDR_CYC       = 4'((ADDR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  DATA_CYC       = 4'((DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic        ALE_POL_RESET  = 1'h1;
  localparam logic [15:0] UPPER_RESET    = 16'h0000;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_UPPER = 3'b001,
    ST_ADDR  = 3'b010,
    ST_TURN  = 3'b011,
    ST_DATA  = 3'b100,
    ST_DONE  = 3'b101
  } mpp_state_t;

  typedef struct packed
  {
    logic        write;
    logic        wide;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mpp_req_t;

  typedef struct packed
  {
    logic [15:0] dout;
    logic        oe_n;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
  } mpp_pins_t;
endpackage : mpp_pkg
`default_nettype wire

// ==== core/mpp_phase_timer.sv ====
// Down counter timing one bus phase of the parallel memory port.
// Loaded with a cycle count; done pulses on the last cycle.
`default_nettype none
module mpp_phase_timer
  import mpp_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [3:0] i_count,
  output logic            o_done
);
  logic [3:0] cnt_reg;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      cnt_reg <= 4'h0;
    else if (i_load)
      cnt_reg <= i_count;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end

  // Done must not look at i_load: the sequencer reloads on done, which would close a loop
  assign o_done = (cnt_reg == 4'h1);
endmodule : mpp_phase_timer
`default_nettype wire

// ==== core/mpp_port.sv ====
// Multiplexed parallel memory port: addresses and data share sixteen lines.
// Assumes requests and pins synchronous to i_mclk; the pull-ups sit on the board.
`default_nettype none
// Overview of operation
// R1 - Address and data share lines; strobe marks address
// R2 - Supports 8-bit and 16-bit data modes
// R3 - 8-bit mode: strobe when upper address changes
// R4 - Read strobe low during every read
// R5 - Write strobe low during every write
// R6 - Flag mode holds all strobes inactive
// R7 - Latch strobe on each new address
// R8 - Latch strobe active high; software may invert
// R9 - Lines undriven until an access begins
// R10 - Address phase ends before data strobes
module mpp_port
  import mpp_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_ale_active_low,
  input  wire logic        i_flag_mode,
  input  wire logic        i_req_valid,
  input  wire mpp_req_t    i_req,
  output logic             o_req_ready,
  output logic             o_rsp_valid,
  output logic [15:0]      o_rsp_rdata,
  input  wire logic [15:0] i_shared_addr_data_lines,
  output logic [15:0]      o_shared_addr_data_lines,
  output logic [15:0]      o_shared_addr_data_lines_oe_n,
  output logic             o_ale,
  output logic             o_rd_n,
  output logic             o_wr_n
);
  mpp_state_t  state_reg;
  mpp_req_t    req_reg;
  logic [15:0] upper_reg;
  logic        upper_valid_reg;
  logic        ale_lvl_reg;
  logic        rd_reg;
  logic        wr_reg;
  logic        oe_reg;
  logic [15:0] dout_reg;
  logic [15:0] rdata_reg;
  logic        rsp_reg;
  logic        tmr_load;
  logic [3:0]  tmr_count;
  logic        tmr_done;
  logic        need_upper;

  mpp_phase_timer u_timer
  (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  // 8-bit mode: upper address bits go out first and are held by the external latch
  assign need_upper = !i_req.wide && (!upper_valid_reg || (i_req.addr[23:8] != upper_reg)); // R3
  assign o_req_ready = (state_reg == ST_IDLE) && !i_flag_mode; // R6

  always_comb
  begin
    tmr_load  = 1'b0;
    tmr_count = ADDR_CYC;
    case (state_reg)
      ST_IDLE:
      begin
        tmr_load = i_req_valid && o_req_ready;
      end
      ST_UPPER, ST_ADDR:
      begin
        tmr_load = tmr_done;
      end
      ST_TURN:
      begin
        tmr_load  = 1'b1;
        tmr_count = DATA_CYC;
      end
      default:
      begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (i_req_valid && o_req_ready)
            state_reg <= need_upper ? ST_UPPER : ST_ADDR;
        ST_UPPER:
          if (tmr_done)
            state_reg <= ST_ADDR;
        ST_ADDR:
          if (tmr_done)
            state_reg <= ST_TURN; // R10
        ST_TURN:
          state_reg <= ST_DATA;
        ST_DATA:
          if (tmr_done)
            state_reg <= ST_DONE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      req_reg <= '0;
    else if (state_reg == ST_IDLE && i_req_valid && o_req_ready)
      req_reg <= i_req;
  end

  // Copy of what the external latch holds
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      upper_reg       <= UPPER_RESET;
      upper_valid_reg <= 1'b0;
    end
    else if (state_reg == ST_UPPER && tmr_done)
    begin
      upper_reg       <= req_reg.addr[23:8]; // R3
      upper_valid_reg <= 1'b1;
    end
  end

  // Line drive: address phases, then write data or release for read
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      oe_reg   <= 1'b0; // R9
      dout_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (i_req_valid && o_req_ready)
          begin
            oe_reg   <= 1'b1; // R1
            dout_reg <= need_upper ? i_req.addr[23:8] : (i_req.wide ? i_req.addr[15:0] : {8'h00, i_req.addr[7:0]});
          end
        ST_UPPER:
          if (tmr_done)
            dout_reg <= {8'h00, req_reg.addr[7:0]};
        ST_ADDR:
          if (tmr_done)
          begin
            oe_reg   <= req_reg.write; // R10
            dout_reg <= req_reg.wide ? req_reg.wdata : {8'h00, req_reg.wdata[7:0]}; // R2
          end
        ST_DONE:
          oe_reg <= 1'b0;
        default:
          oe_reg <= oe_reg;
      endcase
    end
  end

  // Latch strobe high only while an address is on the lines; the one-cycle dip
  // after the upper phase gives the external latch its own capture edge
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      ale_lvl_reg <= 1'b0;
    else if (state_reg == ST_IDLE && i_req_valid && o_req_ready)
      ale_lvl_reg <= 1'b1; // R7
    else if (state_reg == ST_UPPER && tmr_done)
      ale_lvl_reg <= 1'b0; // R3
    else if (state_reg == ST_ADDR && tmr_done)
      ale_lvl_reg <= 1'b0; // R10
    else if (state_reg == ST_ADDR && !ale_lvl_reg)
      ale_lvl_reg <= 1'b1; // R7
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
    else if (state_reg == ST_TURN)
    begin
      rd_reg <= !req_reg.write; // R4
      wr_reg <= req_reg.write; // R5
    end
    else if (state_reg == ST_DATA && tmr_done)
    begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
  end

  // Read data sampled on the last data cycle, before read strobe rises
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_reg <= 16'h0000;
      rsp_reg   <= 1'b0;
    end
    else
    begin
      rsp_reg <= state_reg == ST_DATA && tmr_done;
      if (state_reg == ST_DATA && tmr_done && !req_reg.write)
        rdata_reg <= req_reg.wide ? i_shared_addr_data_lines : {8'h00, i_shared_addr_data_lines[7:0]}; // R2
    end
  end

  assign o_rsp_valid = rsp_reg;
  assign o_rsp_rdata = rdata_reg;
  assign o_shared_addr_data_lines = dout_reg;
  assign o_shared_addr_data_lines_oe_n = {16{!oe_reg}}; // R9
  assign o_ale  = i_flag_mode ? (i_ale_active_low ? 1'b1 : 1'b0)
                              : (ale_lvl_reg ^ i_ale_active_low); // R6 R8
  assign o_rd_n = i_flag_mode ? 1'b1 : !rd_reg; // R6
  assign o_wr_n = i_flag_mode ? 1'b1 : !wr_reg; // R6
endmodule : mpp_port
`default_nettype wire

// ==== sim/mpp_mem_model.sv ====
// Async memory with an address latch on the far side of the port.
// Latch strobe arrives in active-high sense; undriven lines pull up.
`default_nettype none
module mpp_mem_model
(
  input  wire logic [15:0] i_lines,
  input  wire logic        i_ale_act,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  output logic             o_drive,
  output logic [15:0]      o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [15:0] held;
  bit   [15:0]      adr_reg;
  logic [15:0]      mem [256];
  // Lines seen 1 ns late give the latch and the array their hold time
  assign #1 held = i_lines;
  always @(negedge i_ale_act) adr_reg = held;
  always @(posedge i_wr_n) mem[adr_reg[7:0]] = held;
  assign o_drive = !i_rd_n;
  assign o_data = mem[adr_reg[7:0]];
endmodule : mpp_mem_model
`default_nettype wire

// ==== sim/mpp_port_assertions.sv ====
// Pin checker for mpp_port.
// One clock, async active-high reset.
`default_nettype none
module mpp_port_assertions
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_ale_active_low,
  input wire logic        i_flag_mode,
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic        o_rsp_valid,
  input wire logic [15:0] o_shared_addr_data_lines_oe_n,
  input wire logic        o_ale,
  input wire logic        o_rd_n,
  input wire logic        o_wr_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        act;
  logic [15:0] oe;
  assign act = o_ale ^ i_ale_active_low;
  assign oe = o_shared_addr_data_lines_oe_n;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_data(s); !s [*3] ##1 s; endsequence
  property p_flag; i_flag_mode |-> o_rd_n && o_wr_n && !act && !o_req_ready; endproperty
  property p_stb; act |-> o_rd_n && o_wr_n && oe == 16'h0000; endproperty
  property p_rdz; !o_rd_n |-> &oe; endproperty
  property p_wrd; !o_wr_n |-> oe == 16'h0000; endproperty
  property p_idle; o_req_ready |-> &oe && o_rd_n && o_wr_n && !act; endproperty
  property p_take; o_req_ready && i_req_valid |=> act [*2]; endproperty
  property p_wr; $fell(act) && oe == 16'h0000 ##1 !act |-> s_data(o_wr_n) ##0 o_rsp_valid; endproperty
  property p_rd; $fell(act) && &oe |=> s_data(o_rd_n) ##0 o_rsp_valid; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  a_stb: assert property (p_stb) else $error("addr");
  a_rdz: assert property (p_rdz) else $error("rdz");
  a_wrd: assert property (p_wrd) else $error("wrd");
  a_idle: assert property (p_idle) else $error("idle");
  a_take: assert property (p_take) else $error("take");
  a_wr: assert property (p_wr) else $error("wr");
  a_rd: assert property (p_rd) else $error("rd");
endmodule : mpp_port_assertions
bind mpp_port mpp_port_assertions u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_ale_active_low(i_ale_active_low),
  .i_flag_mode(i_flag_mode), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
  .o_shared_addr_data_lines_oe_n(o_shared_addr_data_lines_oe_n), .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));
`default_nettype wire

// ==== sim/test_mpp_port.sv ====
// Bench for mpp_port with the memory model on the lines.
// Inputs change 2 ns after each rising edge.
`default_nettype none
module test_mpp_port
  import mpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic             clk, rst, pol, flag, vld, rdy, rv, ale, rd_n, wr_n, drv;
  mpp_req_t         req;
  logic [15:0]      rdata, dout, oe_n, mdata, q;
  wire logic [15:0] lines;
  int               err_count, checks_done, cyc, n;
  // Released lines sit at the pull-up level
  assign lines = !oe_n[0] ? dout : drv ? mdata : 16'hFFFF;
  mpp_port uut (.i_mclk(clk), .i_rst(rst), .i_ale_active_low(pol), .i_flag_mode(flag), .i_req_valid(vld),
    .i_req(req), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(rdata), .i_shared_addr_data_lines(lines),
    .o_shared_addr_data_lines(dout), .o_shared_addr_data_lines_oe_n(oe_n), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n));
  mpp_mem_model mem (.i_lines(lines), .i_ale_act(ale ^ pol), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_drive(drv),
    .o_data(mdata));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One access; n ends as cycles from take to response
  task automatic acc(input logic w, wd, input logic [23:0] a, input logic [15:0] d);
    req = '{w, wd, a, d};
    vld = 1'b1;
    for (n = 0; n < 40 && rdy !== 1'b1; n++) @(posedge clk) #2;
    @(posedge clk) #2;
    vld = 1'b0;
    for (n = 0; n < 40 && rv !== 1'b1; n++) @(posedge clk) #2;
    q = rdata;
  endtask : acc
  task automatic t_byte;
    acc(1'b1, 1'b0, 24'hABCD12, 16'h0055);
    chk(16'(n), 16'h0008);
    acc(1'b0, 1'b0, 24'hABCD12, 16'h0000);
    chk(q, 16'h0055);
    chk(16'(n), 16'h0006);
    acc(1'b0, 1'b0, 24'h12CD12, 16'h0000);
    chk(16'(n), 16'h0008);
    $display("byte end");
  endtask : t_byte
  task automatic t_wide;
    acc(1'b1, 1'b1, 24'h001234, 16'hBEEF);
    chk(16'(n), 16'h0006);
    $display("wide end");
  endtask : t_wide
  task automatic t_flag;
    flag = 1'b1;
    req = '{1'b0, 1'b1, 24'h001234, 16'h0000};
    vld = 1'b1;
    repeat (4) @(posedge clk) #2;
    chk({12'h000, rdy, rd_n, wr_n, ale}, 16'h0006);
    flag = 1'b0;
    acc(1'b0, 1'b1, 24'h001234, 16'h0000);
    chk(q, 16'hBEEF);
    $display("flag end");
  endtask : t_flag
  task automatic t_pol;
    pol = 1'b1;
    @(posedge clk) #2;
    chk({15'h0000, ale}, 16'h0001);
    acc(1'b1, 1'b1, 24'h000777, 16'h1357);
    acc(1'b0, 1'b1, 24'h000777, 16'h0000);
    chk(q, 16'h1357);
    $display("polarity end");
  endtask : t_pol
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    {rst, pol, flag, vld} = 4'h8;
    req = '0;
    repeat (2) @(posedge clk) #2;
    chk({oe_n[15:3], rd_n, wr_n, ale}, 16'hFFFE);
    rst = 1'b0;
    t_byte();
    t_wide();
    t_flag();
    t_pol();
    give_verdict();
  end
endmodule : test_mpp_port
`default_nettype wire
